// >>> rtl/lcd_pkg.sv
// Shared constants and carriers for the legacy opcode compatibility decoder.
// Assumes a single core clock and an AHB-Lite register port with 32-bit words.
package lcd_pkg;

	// Register byte offsets
	localparam logic [7:0] LCD_OFS_CTRL = 8'h00; // Mode controls
	localparam logic [7:0] LCD_OFS_INSN = 8'h04; // Opcode, operand mode byte, prefix count
	localparam logic [7:0] LCD_OFS_IMM = 8'h08; // Immediate operand, low bits as shift count
	localparam logic [7:0] LCD_OFS_EXEC = 8'h0c; // Any write executes the held instruction
	localparam logic [7:0] LCD_OFS_STATUS = 8'h10; // Result of the last execution
	localparam logic [7:0] LCD_OFS_ACC = 8'h14; // Accumulator
	localparam logic [7:0] LCD_OFS_FLAGS = 8'h18; // Flags register
	localparam logic [7:0] LCD_OFS_SP = 8'h1c; // Stack pointer
	localparam logic [7:0] LCD_OFS_PUSH = 8'h20; // Last word pushed

	// Control field positions
	localparam int LCD_CTRL_LONG = 0; // 64-bit mode
	localparam int LCD_CTRL_REAL = 1; // Real-address mode

	// Instruction register fields
	localparam int LCD_INSN_OP0 = 0; // First opcode byte, bits 7:0
	localparam int LCD_INSN_OP1 = 8; // Second opcode byte, bits 15:8
	localparam int LCD_INSN_MODRM = 16; // Operand mode byte, bits 23:16
	localparam int LCD_INSN_PFX = 24; // Prefix count, bits 27:24

	// Status field positions
	localparam int LCD_ST_FAULT = 0; // Invalid opcode fault
	localparam int LCD_ST_DEFER = 1; // Left to the main core
	localparam int LCD_ST_LEN = 8; // Instruction length, bits 12:8
	localparam int LCD_ST_KIND = 16; // Decoded kind, bits 19:16

	// Flags register bit positions
	localparam int LCD_FL_CARRY = 0; // carry_flag
	localparam int LCD_FL_ZF = 6;
	localparam int LCD_FL_SF = 7;
	localparam int LCD_FL_OF = 11;
	localparam int LCD_FL_RSV15 = 15;
	localparam int LCD_FL_ALIGN = 18; // alignment_check_flag
	localparam int LCD_FL_VINT = 19; // virtual_interrupt_flag
	localparam int LCD_FL_VPEND = 20; // virtual_interrupt_pending
	localparam int LCD_FL_IDENT = 21; // identification_flag
	localparam logic [31:0] LCD_FL_WMASK = 32'h0027_7fd5; // Writable without virtual mode
	localparam logic [31:0] LCD_FL_VMASK = 32'h0018_0000; // Bits 19 and 20
	localparam logic [31:0] LCD_FL_FIXED = 32'h0000_0002; // Bit 1 always reads one
	localparam logic [31:0] LCD_FL_RESET = 32'h0000_0002;

	localparam logic [31:0] LCD_PUSH_STEP = 32'h0000_0004; // Stack slot size
	localparam logic [7:0] LCD_BYTE_ONES = 8'hff;

	// Decoded kinds
	typedef enum logic [3:0] {
		LCD_K_FAULT,
		LCD_K_ALU,
		LCD_K_SHIFT,
		LCD_K_TEST,
		LCD_K_UNARY,
		LCD_K_DEFER,
		LCD_K_NOP,
		LCD_K_CARRYBYTE,
		LCD_K_PUSHSP,
		LCD_K_PUSHFLAGS
	} lcd_kind_t;

	// Decoder result
	typedef struct packed {
		lcd_kind_t kind;
		logic [2:0] sub; // Effective reg_field after aliasing
		logic wide; // Word operand, else low byte
		logic [4:0] len; // Total length in bytes
	} lcd_dec_t;

	// Execution unit result
	typedef struct packed {
		logic [31:0] res;
		logic carry;
		logic zf;
		logic sf;
		logic of;
		logic wr; // Destination written
		logic [3:0] upd; // Update of, sf, zf, cf
	} lcd_alu_t;

endpackage : lcd_pkg

// >>> rtl/lcd_decode.sv
// Opcode decoder: kind, aliased reg_field, operand width and length.
// Assumes opcode bytes, operand mode byte and prefix count are held stable.
module lcd_decode
(
	input wire logic [7:0] op0,
	input wire logic [7:0] op1,
	input wire logic [7:0] modrm,
	input wire logic [3:0] pfx_cnt,
	input wire logic long_mode,
	output lcd_pkg::lcd_dec_t dec
);
	import lcd_pkg::*;

	logic has_modrm; // Operand mode byte follows
	logic [4:0] imm_len; // Immediate bytes
	logic [4:0] mod_len; // Operand mode byte, index byte, displacement

	// Opcode classification
	always_comb
	begin
		dec.kind = LCD_K_FAULT;
		dec.sub = modrm[5:3];
		dec.wide = op0[0];
		dec.len = 5'({1'b0, pfx_cnt}) + 5'd1;
		has_modrm = 1'b0;
		imm_len = 5'd0;
		unique case (op0)
			8'h80:
			begin
				dec.kind = LCD_K_ALU;
				has_modrm = 1'b1;
				imm_len = 5'd1;
			end
			8'h82:
			begin
				// Alias of the byte immediate group outside 64-bit mode
				dec.kind = long_mode ? LCD_K_FAULT : LCD_K_ALU;
				dec.wide = 1'b0;
				has_modrm = 1'b1;
				imm_len = 5'd1;
			end
			8'hc0, 8'hc1, 8'hd0, 8'hd1, 8'hd2, 8'hd3:
			begin
				dec.kind = LCD_K_SHIFT;
				has_modrm = 1'b1;
				imm_len = (op0[7:4] == 4'hc) ? 5'd1 : 5'd0;
				if (modrm[5:3] == 3'b110)
				begin
					dec.sub = 3'b100;
				end
			end
			8'hf6, 8'hf7:
			begin
				has_modrm = 1'b1;
				if (modrm[5:4] == 2'b00)
				begin
					// Both test encodings share one path
					dec.kind = LCD_K_TEST;
					dec.sub = 3'b000;
					imm_len = op0[0] ? 5'd4 : 5'd1;
				end
				else if (modrm[5:4] == 2'b01)
				begin
					dec.kind = LCD_K_UNARY;
				end
				else
				begin
					// Multiply and divide live in the main core
					dec.kind = LCD_K_DEFER;
				end
			end
			8'hd6:
			begin
				dec.kind = long_mode ? LCD_K_FAULT : LCD_K_CARRYBYTE;
			end
			8'h54:
			begin
				dec.kind = LCD_K_PUSHSP;
			end
			8'h9c:
			begin
				dec.kind = LCD_K_PUSHFLAGS;
			end
			8'h0f:
			begin
				dec.len = dec.len + 5'd1;
				if (op1 == 8'h0d || op1[7:3] == 5'b00011)
				begin
					dec.kind = LCD_K_NOP;
					has_modrm = 1'b1;
				end
				else
				begin
					// Test register moves and all else reserved
					dec.kind = LCD_K_FAULT;
				end
			end
			default:
			begin
				dec.kind = LCD_K_FAULT;
			end
		endcase
		// Length from operand mode byte, 32-bit addressing
		mod_len = 5'd0;
		if (has_modrm)
		begin
			mod_len = 5'd1;
			if (modrm[7:6] != 2'b11 && modrm[2:0] == 3'b100)
			begin
				mod_len = mod_len + 5'd1;
			end
			if (modrm[7:6] == 2'b01)
			begin
				mod_len = mod_len + 5'd1;
			end
			else if (modrm[7:6] == 2'b10 || (modrm[7:6] == 2'b00 && modrm[2:0] == 3'b101))
			begin
				mod_len = mod_len + 5'd4;
			end
		end
		dec.len = dec.len + mod_len + imm_len;
	end

endmodule : lcd_decode

// >>> rtl/lcd_alu.sv
// Execution unit for the arithmetic, shift, test and unary groups.
// Operates on the accumulator; byte forms keep accumulator bits 31:8.
module lcd_alu
(
	input lcd_pkg::lcd_dec_t dec,
	input wire logic [31:0] a,
	input wire logic [31:0] b,
	input wire logic [4:0] cnt,
	input wire logic carry_in,
	output lcd_pkg::lcd_alu_t out
);
	import lcd_pkg::*;

	// Operation body; aliases already folded in by the decoder
	always_comb
	begin
		logic [31:0] ax;
		logic [31:0] bx;
		logic [32:0] r33;
		logic [31:0] v;
		logic c;
		logic top;
		logic sa;
		logic sb;
		logic sr;
		sa = 1'b0;
		sb = 1'b0;
		sr = 1'b0;
		ax = dec.wide ? a : {24'h000000, a[7:0]};
		bx = dec.wide ? b : {24'h000000, b[7:0]};
		r33 = 33'h0;
		v = ax;
		c = carry_in;
		top = 1'b0;
		out.of = 1'b0;
		out.wr = 1'b0;
		out.upd = 4'h0;
		unique case (dec.kind)
			LCD_K_ALU, LCD_K_TEST:
			begin
				out.upd = 4'hf;
				out.wr = (dec.kind == LCD_K_ALU) && (dec.sub != 3'd7);
				unique case (dec.kind == LCD_K_TEST ? 3'd4 : dec.sub)
					3'd0: r33 = {1'b0, ax} + {1'b0, bx};
					3'd1: r33 = {1'b0, ax | bx};
					3'd2: r33 = {1'b0, ax} + {1'b0, bx} + {32'h0, carry_in};
					3'd3: r33 = {1'b0, ax} - {1'b0, bx} - {32'h0, carry_in};
					3'd4: r33 = {1'b0, ax & bx};
					3'd5, 3'd7: r33 = {1'b0, ax} - {1'b0, bx};
					3'd6: r33 = {1'b0, ax ^ bx};
				endcase
				v = r33[31:0];
				c = dec.wide ? r33[32] : r33[8];
			end
			LCD_K_UNARY:
			begin
				// Not leaves flags alone, negate sets them
				out.wr = 1'b1;
				out.upd = dec.sub[0] ? 4'hf : 4'h0;
				v = dec.sub[0] ? (32'h0 - ax) : ~ax;
				c = (ax != 32'h0);
			end
			LCD_K_SHIFT:
			begin
				// One bit per step; count zero changes nothing
				out.wr = 1'b1;
				out.upd = (cnt == 5'd0) ? 4'h0 : (dec.sub[2] ? 4'h7 : 4'h1);
				for (int i = 0; i < 32; i++)
				begin
					if (i < int'(cnt))
					begin
						top = dec.wide ? v[31] : v[7];
						unique case (dec.sub)
							3'd0: {c, v} = {top, v[30:0], top};
							3'd1: {c, v} = {v[0], 1'b0, v[31:1]};
							3'd2: {c, v} = {top, v[30:0], c};
							3'd3: {c, v} = {v[0], c, v[31:1]};
							3'd4, 3'd6: {c, v} = {top, v[30:0], 1'b0};
							3'd5: {c, v} = {v[0], 1'b0, v[31:1]};
							3'd7: {c, v} = {v[0], top, v[31:1]};
						endcase
						// Carry-in of right moves lands at the byte top
						if (!dec.wide)
						begin
							if (dec.sub[0] && dec.sub != 3'd5)
							begin
								v[7] = (dec.sub == 3'd1) ? v[31] : (dec.sub == 3'd3 ? v[31] : top);
							end
							v = {24'h000000, v[7:0]};
						end
					end
				end
			end
			default:
			begin
				out.wr = 1'b0;
			end
		endcase
		sa = dec.wide ? ax[31] : ax[7];
		sb = dec.wide ? bx[31] : bx[7];
		sr = dec.wide ? v[31] : v[7];
		if (dec.kind == LCD_K_ALU && (dec.sub == 3'd0 || dec.sub == 3'd2))
		begin
			out.of = (sa == sb) && (sr != sa);
		end
		else if (dec.kind == LCD_K_ALU && (dec.sub == 3'd3 || dec.sub[2:1] == 2'b11 ||
			dec.sub == 3'd5))
		begin
			out.of = (dec.sub != 3'd6) && (sa != sb) && (sr != sa);
		end
		else if (dec.kind == LCD_K_UNARY)
		begin
			out.of = sa && sr;
		end
		if (dec.kind == LCD_K_ALU && (dec.sub == 3'd1 || dec.sub == 3'd4 || dec.sub == 3'd6))
		begin
			c = 1'b0;
		end
		if (dec.kind == LCD_K_TEST)
		begin
			c = 1'b0;
		end
		out.carry = c;
		out.sf = sr;
		out.zf = dec.wide ? (v == 32'h0) : (v[7:0] == 8'h00);
		out.res = dec.wide ? v : {a[31:8], v[7:0]};
	end

endmodule : lcd_alu

// >>> rtl/lcd_core.sv
// Legacy opcode compatibility decoder with its architectural state.
// Assumes one AHB-Lite master, single word transfers, hready = hreadyout.
//
// Summary of operation
// - Test register moves raise invalid opcode fault
// - Other reserved encodings raise invalid opcode fault
// - Opcode 82H runs as 80H outside 64-bit
// - Opcode 82H faults in 64-bit mode
// - Shift reg_field 110B acts as 100B
// - Unary reg_field 001B acts as test 000B
// - Reserved hint opcodes execute as no-operation
// - Hint opcodes decode full length, do nothing
// - D6H sets low byte from carry
// - D6H faults in 64-bit mode
// - Virtual flags bits 19, 20; identification 21
// - Alignment check bit 18 is writable
// - Identification bit toggles, showing identify instruction
// - Without virtual extensions bits 19, 20 zero
// - Push stack_pointer stores pre-decrement value
// - Real mode pushed flags: bit 15 zero
module lcd_core
#(
	parameter bit VME_PRESENT = 1'b1 // Virtual mode extensions fitted
)
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic invalid_opcode_fault
);
	import lcd_pkg::*;

	// Bus slave state
	logic resp_reg; // Response, held at OKAY
	logic [31:0] rdata_reg;
	logic [31:0] rdata_next;
	logic wr_pend_reg; // Write data phase pending
	logic wr_pend_next;
	logic [7:0] wr_addr_reg; // Offset of pending write
	logic [7:0] wr_addr_next;
	logic ready_reg; // Always ready once out of reset
	logic addr_ok; // Valid address phase

	// Architectural and control state
	// All software visible; the status fields and push word are read-only
	logic [1:0] ctrl_reg;
	logic [1:0] ctrl_next;
	logic [31:0] insn_reg;
	logic [31:0] insn_next;
	logic [31:0] imm_reg;
	logic [31:0] imm_next;
	logic [31:0] acc_reg; // low_accumulator_byte is bits 7:0
	logic [31:0] acc_next;
	logic [31:0] flags_reg;
	logic [31:0] flags_next;
	logic [31:0] sp_reg;
	logic [31:0] sp_next;
	logic [31:0] push_reg;
	logic [31:0] push_next;
	logic fault_reg;
	logic fault_next;
	logic defer_reg;
	logic defer_next;
	logic [4:0] len_reg;
	logic [4:0] len_next;
	lcd_kind_t kind_reg;
	lcd_kind_t kind_next;

	// Decode and execute run purely from held registers
	lcd_dec_t dec; // Decoded held instruction
	lcd_alu_t alu; // Execution result
	logic exec_go; // Execute this cycle

	// Writable flag bits; virtual bits only when fitted
	// Bit 15 has no storage, so pushes never carry it
	function automatic logic [31:0] flags_clean(input logic [31:0] v);
		logic [31:0] m;
		m = LCD_FL_WMASK | (VME_PRESENT ? LCD_FL_VMASK : 32'h0000_0000);
		return (v & m) | LCD_FL_FIXED;
	endfunction : flags_clean

	// Decoder instance
	lcd_decode u_decode
	(
		.op0(insn_reg[LCD_INSN_OP0 +: 8]),
		.op1(insn_reg[LCD_INSN_OP1 +: 8]),
		.modrm(insn_reg[LCD_INSN_MODRM +: 8]),
		.pfx_cnt(insn_reg[LCD_INSN_PFX +: 4]),
		.long_mode(ctrl_reg[LCD_CTRL_LONG]),
		.dec(dec)
	);

	// Execution unit instance; immediate low bits stand in for the count register
	lcd_alu u_alu
	(
		.dec(dec),
		.a(acc_reg),
		.b(imm_reg),
		.cnt((dec.kind == LCD_K_SHIFT && insn_reg[4] && !insn_reg[1]) ? 5'd1 : imm_reg[4:0]),
		.carry_in(flags_reg[LCD_FL_CARRY]),
		.out(alu)
	);

	// IDLE and BUSY never start a transfer
	assign addr_ok = hsel && hready && htrans[1];
	// Runs in the data phase of a write to the execute offset
	assign exec_go = wr_pend_reg && (wr_addr_reg == LCD_OFS_EXEC);

	// Bus address and data phases
	always_comb
	begin
		// A pending write lasts one data phase
		wr_pend_next = addr_ok && hwrite;
		wr_addr_next = addr_ok ? haddr[7:0] : wr_addr_reg;
		rdata_next = rdata_reg;
		// Read data captured at the address phase, so no wait states
		if (addr_ok && !hwrite)
		begin
			unique case (haddr[7:0])
				LCD_OFS_CTRL: rdata_next = {30'h0, ctrl_reg};
				LCD_OFS_INSN: rdata_next = insn_reg;
				LCD_OFS_IMM: rdata_next = imm_reg;
				LCD_OFS_STATUS:
				begin
					rdata_next = 32'h0;
					rdata_next[LCD_ST_FAULT] = fault_reg;
					rdata_next[LCD_ST_DEFER] = defer_reg;
					rdata_next[LCD_ST_LEN +: 5] = len_reg;
					rdata_next[LCD_ST_KIND +: 4] = kind_reg;
				end
				LCD_OFS_ACC: rdata_next = acc_reg;
				LCD_OFS_FLAGS: rdata_next = flags_reg;
				LCD_OFS_SP: rdata_next = sp_reg;
				LCD_OFS_PUSH: rdata_next = push_reg;
				// Unmapped and write-only offsets read zero
				default: rdata_next = 32'h0;
			endcase
		end
	end

	// Bus slave registers
	// Ready rises an edge after reset, so no transfer meets it
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ready_reg <= 1'b0;
			resp_reg <= 1'b0;
			rdata_reg <= 32'h0;
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= 8'h00;
		end
		else
		begin
			ready_reg <= 1'b1;
			resp_reg <= 1'b0; // Errors are never signalled
			rdata_reg <= rdata_next;
			wr_pend_reg <= wr_pend_next;
			wr_addr_reg <= wr_addr_next;
		end
	end

	// Software writes and instruction execution
	// Execution sees state held before its own edge
	// One instruction per execute write, no pipelining
	always_comb
	begin
		ctrl_next = ctrl_reg;
		insn_next = insn_reg;
		imm_next = imm_reg;
		acc_next = acc_reg;
		flags_next = flags_reg;
		sp_next = sp_reg;
		push_next = push_reg;
		fault_next = fault_reg;
		defer_next = defer_reg;
		len_next = len_reg;
		kind_next = kind_reg;
		if (wr_pend_reg)
		begin
			// Data phase of a write; hsize is always a word here
			// Read-only and unmapped offsets take the default arm
			unique case (wr_addr_reg)
				LCD_OFS_CTRL: ctrl_next = hwdata[1:0];
				LCD_OFS_INSN: insn_next = hwdata;
				LCD_OFS_IMM: imm_next = hwdata;
				LCD_OFS_ACC: acc_next = hwdata;
				LCD_OFS_FLAGS: flags_next = flags_clean(hwdata);
				LCD_OFS_SP: sp_next = hwdata;
				default: ctrl_next = ctrl_reg;
			endcase
		end
		if (exec_go)
		begin
			kind_next = dec.kind;
			len_next = dec.len;
			fault_next = (dec.kind == LCD_K_FAULT);
			defer_next = (dec.kind == LCD_K_DEFER);
			unique case (dec.kind)
				LCD_K_ALU, LCD_K_SHIFT, LCD_K_TEST, LCD_K_UNARY:
				begin
					// Aliases reach here already mapped to their twins
					if (alu.wr)
					begin
						acc_next = alu.res;
					end
					if (alu.upd[0])
					begin
						flags_next[LCD_FL_CARRY] = alu.carry;
					end
					if (alu.upd[1])
					begin
						flags_next[LCD_FL_ZF] = alu.zf;
					end
					if (alu.upd[2])
					begin
						flags_next[LCD_FL_SF] = alu.sf;
					end
					if (alu.upd[3])
					begin
						flags_next[LCD_FL_OF] = alu.of;
					end
				end
				// Only the low byte changes
				LCD_K_CARRYBYTE:
				begin
					acc_next[7:0] = flags_reg[LCD_FL_CARRY] ? LCD_BYTE_ONES : 8'h00;
				end
				LCD_K_PUSHSP:
				begin
					// Pointer value from before the decrement
					push_next = sp_reg;
					sp_next = sp_reg - LCD_PUSH_STEP;
				end
				LCD_K_PUSHFLAGS:
				begin
					// Bits 12 to 14 go out as last loaded
					push_next = flags_reg;
					if (ctrl_reg[LCD_CTRL_REAL])
					begin
						push_next[LCD_FL_RSV15] = 1'b0;
					end
					sp_next = sp_reg - LCD_PUSH_STEP;
				end
				// Fault, hint and deferred kinds leave state untouched
				LCD_K_NOP, LCD_K_FAULT, LCD_K_DEFER:
				begin
					acc_next = acc_reg;
				end
			endcase
		end
	end

	// Architectural registers
	// Reset status shows a harmless no-operation
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ctrl_reg <= 2'b00;
			insn_reg <= 32'h0000_0000;
			imm_reg <= 32'h0000_0000;
			acc_reg <= 32'h0000_0000;
			flags_reg <= LCD_FL_RESET;
			sp_reg <= 32'h0000_0000;
			push_reg <= 32'h0000_0000;
			fault_reg <= 1'b0;
			defer_reg <= 1'b0;
			len_reg <= 5'h00;
			kind_reg <= LCD_K_NOP;
		end
		else
		begin
			ctrl_reg <= ctrl_next;
			insn_reg <= insn_next;
			imm_reg <= imm_next;
			acc_reg <= acc_next;
			flags_reg <= flags_next;
			sp_reg <= sp_next;
			push_reg <= push_next;
			fault_reg <= fault_next;
			defer_reg <= defer_next;
			len_reg <= len_next;
			kind_reg <= kind_next;
		end
	end

	// Outputs straight from flip-flops; response is always OKAY
	assign hreadyout = ready_reg;
	assign hresp = resp_reg;
	assign hrdata = rdata_reg;
	assign invalid_opcode_fault = fault_reg;

endmodule : lcd_core

// >>> sim/lcd_monitor.sv
// Checker for the compatibility decoder: fault output against the held opcode.
// Assumes a zero-wait slave whose hready is fed from hreadyout.
module lcd_monitor
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic invalid_opcode_fault
);
	timeunit 1ns;
	timeprecision 100ps;
	import lcd_pkg::*;
	logic wr_reg; // Write data phase pending
	logic [7:0] adr_reg; // Its byte address
	logic [31:0] insn_reg; // Shadow of the instruction word
	logic long_reg; // Shadow of 64-bit mode
	logic ex; // Execute request at this edge
	logic [7:0] o0;
	logic [7:0] o1;
	logic [2:0] rg; // Reg field of the mode byte
	assign o0 = insn_reg[7:0];
	assign o1 = insn_reg[15:8];
	assign rg = insn_reg[21:19];
	assign ex = wr_reg && hready && adr_reg == LCD_OFS_EXEC;
	// Opcodes that must run; the rest must fault
	function automatic logic known(input logic [7:0] a, input logic [7:0] b, input logic lm);
		known = a inside {8'hc0, 8'hc1, 8'hd0, 8'hd1, 8'hd2, 8'hd3, 8'hf6, 8'hf7, 8'h80}
			|| a inside {8'h54, 8'h9c} || (!lm && a inside {8'h82, 8'hd6})
			|| (a == 8'h0f && (b == 8'h0d || b[7:3] == 5'h03));
	endfunction : known
	// Shadows follow write data phases, so the check sees what the core holds
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_reg <= 1'b0;
			adr_reg <= 8'h00;
			insn_reg <= 32'h0000_0000;
			long_reg <= 1'b0;
		end
		else
		begin
			wr_reg <= hsel && hready && htrans[1] && hwrite;
			adr_reg <= haddr[7:0];
			if (wr_reg && hready && adr_reg == LCD_OFS_INSN)
				insn_reg <= hwdata;
			if (wr_reg && hready && adr_reg == LCD_OFS_CTRL)
				long_reg <= hwdata[LCD_CTRL_LONG];
		end
	end
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	property p_test_reg;
		ex && o0 == 8'h0f && o1 inside {8'h24, 8'h26} |=> invalid_opcode_fault;
	endproperty
	a_test_reg: assert property (p_test_reg) else $error("test register move ran");
	property p_reserved;
		ex && !known(o0, o1, long_reg) |=> invalid_opcode_fault;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved opcode ran");
	property p_imm_alias;
		ex && !long_reg && o0 == 8'h82 |=> !invalid_opcode_fault;
	endproperty
	a_imm_alias: assert property (p_imm_alias) else $error("82 faulted outside long");
	property p_imm_long;
		ex && long_reg && o0 == 8'h82 |=> invalid_opcode_fault;
	endproperty
	a_imm_long: assert property (p_imm_long) else $error("82 ran in long mode");
	property p_shift_alias;
		ex && o0 inside {8'hc0, 8'hc1, 8'hd0, 8'hd1, 8'hd2, 8'hd3} && rg == 3'b110
			|=> !invalid_opcode_fault;
	endproperty
	a_shift_alias: assert property (p_shift_alias) else $error("shift 110 faulted");
	property p_test_alias;
		ex && o0 inside {8'hf6, 8'hf7} && rg == 3'b001 |=> !invalid_opcode_fault;
	endproperty
	a_test_alias: assert property (p_test_alias) else $error("test 001 faulted");
	property p_hint_nop;
		ex && o0 == 8'h0f && (o1 == 8'h0d || o1[7:3] == 5'h03) |=> !invalid_opcode_fault;
	endproperty
	a_hint_nop: assert property (p_hint_nop) else $error("hint opcode faulted");
	property p_set_byte_from_carry;
		ex && !long_reg && o0 == 8'hd6 |=> !invalid_opcode_fault;
	endproperty
	a_set_byte_from_carry: assert property (p_set_byte_from_carry) else $error("d6 faulted outside long");
	property p_set_byte_from_carry_long;
		ex && long_reg && o0 == 8'hd6 |=> invalid_opcode_fault;
	endproperty
	a_set_byte_from_carry_long: assert property (p_set_byte_from_carry_long) else $error("d6 ran in long mode");
	property p_fault_hold;
		!ex |=> $stable(invalid_opcode_fault);
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault moved without exec");
	c_alias: cover property (ex && o0 == 8'h82);
	c_set_byte_from_carry_long: cover property (ex && long_reg && o0 == 8'hd6);
	c_hint: cover property (ex && o0 == 8'h0f);
endmodule : lcd_monitor

bind lcd_core lcd_monitor i_lcd_monitor (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.invalid_opcode_fault(invalid_opcode_fault));

// >>> sim/lcd_core_tb.sv
// Self-checking bench for the decoder, driven as one AHB-Lite master.
// Assumes zero-wait slaves; a second core without virtual mode shares the bus.
module lcd_core_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import lcd_pkg::*;
	logic hclk, hresetn, hsel, hwrite;
	logic [31:0] haddr, hwdata, rv, rv2;
	logic [1:0] htrans;
	logic [2:0] hsize;
	wire logic hready, hreadyout, hresp, invalid_opcode_fault;
	wire logic [31:0] hrdata, hrdata2;
	int fail_count = 0;
	int checks = 0;
	logic [7:0] alu_exp [8] = '{8'h96, 8'h7e, 8'h96, 8'h1e, 8'h18, 8'h1e, 8'h66, 8'h5a};
	assign hready = hreadyout; // Single slave drives bus ready
	lcd_core i_lcd_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.invalid_opcode_fault(invalid_opcode_fault));
	// Variant without virtual mode, shadowing every transfer
	lcd_core #(.VME_PRESENT(1'b0)) i_lcd_core_novme (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(), .hresp(), .hrdata(hrdata2),
		.invalid_opcode_fault());
	// Clock, 5 ns period
	initial
	begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	task automatic report_and_stop;
		if (fail_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : report_and_stop
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// One single transfer; entered just after a rising edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		htrans <= 2'b00;
		hwdata <= wd;
		@(posedge hclk);
		while (hready !== 1'b1)
			@(posedge hclk);
		rv = hrdata;
		rv2 = hrdata2;
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		xfer(1'b0, a, 32'h0);
	endtask : rd
	// Load mode, instruction and immediate, execute, then read status
	task automatic run(input logic [31:0] c, input logic [31:0] i, input logic [31:0] m,
		input logic f);
		wr(LCD_OFS_CTRL, c);
		wr(LCD_OFS_INSN, i);
		wr(LCD_OFS_IMM, m);
		wr(LCD_OFS_EXEC, 32'h0);
		rd(LCD_OFS_STATUS);
		chk({30'h0, rv[LCD_ST_FAULT], invalid_opcode_fault}, {30'h0, f, f});
	endtask : run
	task automatic sc_reset;
		rd(LCD_OFS_FLAGS);
		chk(rv, 32'h0000_0002);
		rd(LCD_OFS_STATUS);
		chk(rv, 32'h0006_0000);
		chk({30'h0, hreadyout, hresp}, 32'h2);
	endtask : sc_reset
	// Faulting encodings leave the accumulator alone; hints do nothing
	task automatic sc_faults;
		wr(LCD_OFS_ACC, 32'h1234_5678);
		run(32'h0, 32'h0000_240f, 32'h0, 1'b1);
		run(32'h0, 32'h0000_260f, 32'h0, 1'b1);
		run(32'h0, 32'h0000_00f1, 32'h0, 1'b1);
		run(32'h1, 32'h00c0_0082, 32'h0, 1'b1);
		run(32'h1, 32'h0000_00d6, 32'h0, 1'b1);
		run(32'h0, 32'h00c0_0d0f, 32'h0, 1'b0);
		for (int k = 8'h18; k <= 8'h1f; k++)
			run(32'h0, {8'h00, 8'hc0, 8'(k), 8'h0f}, 32'h0, 1'b0);
		run(32'h0, 32'h0244_180f, 32'h0, 1'b0);
		chk({27'h0, rv[12:8]}, 32'd7);
		rd(LCD_OFS_ACC);
		chk(rv, 32'h1234_5678);
	endtask : sc_faults
	// Both immediate groups over every reg field, carry clear
	task automatic sc_alu;
		wr(LCD_OFS_FLAGS, 32'h0);
		for (int k = 0; k < 16; k++)
		begin
			wr(LCD_OFS_ACC, 32'haa00_005a);
			run(32'h0, {8'h00, 2'b11, 3'(k), 3'b000, 8'h00, (k < 8) ? 8'h80 : 8'h82}, 32'h3c,
				1'b0);
			rd(LCD_OFS_ACC);
			chk(rv, {24'haa00_00, alu_exp[k % 8]});
		end
	endtask : sc_alu
	// Reg field 110 shifts left by one on every shift opcode
	task automatic sc_shift;
		logic [7:0] ops [6];
		ops = '{8'hc0, 8'hc1, 8'hd0, 8'hd1, 8'hd2, 8'hd3};
		foreach (ops[k])
		begin
			wr(LCD_OFS_ACC, 32'h8000_0081);
			run(32'h0, {16'h00f0, 8'h00, ops[k]}, 32'h1, 1'b0);
			rd(LCD_OFS_ACC);
			chk(rv, ops[k][0] ? 32'h0000_0102 : 32'h8000_0002);
			rd(LCD_OFS_FLAGS);
			chk({31'h0, rv[LCD_FL_CARRY]}, 32'h1);
		end
	endtask : sc_shift
	// Reg field 001 of the unary group tests, with immediate in length
	task automatic sc_test;
		wr(LCD_OFS_ACC, 32'h8000_0081);
		run(32'h0, 32'h00c8_00f6, 32'h0, 1'b0);
		chk({12'h0, rv[19:16], 3'h0, rv[12:8], 8'h0}, 32'h0003_0300);
		rd(LCD_OFS_FLAGS);
		chk({31'h0, rv[LCD_FL_ZF]}, 32'h1);
		run(32'h0, 32'h00c8_00f7, 32'h8000_0000, 1'b0);
		chk({27'h0, rv[12:8]}, 32'd6);
		rd(LCD_OFS_FLAGS);
		chk({30'h0, rv[LCD_FL_SF], rv[LCD_FL_ZF]}, 32'h2);
		rd(LCD_OFS_ACC);
		chk(rv, 32'h8000_0081);
		run(32'h0, 32'h00d0_00f6, 32'h0, 1'b0);
		rd(LCD_OFS_ACC);
		chk(rv, 32'h8000_007e);
		run(32'h0, 32'h00e0_00f6, 32'h0, 1'b0);
		chk({31'h0, rv[LCD_ST_DEFER]}, 32'h1);
	endtask : sc_test
	// Low byte follows carry, upper bytes kept
	task automatic sc_set_byte_from_carry;
		for (int k = 1; k >= 0; k--)
		begin
			wr(LCD_OFS_FLAGS, 32'(k));
			wr(LCD_OFS_ACC, 32'h1234_5600);
			run(32'h0, 32'h0000_00d6, 32'h0, 1'b0);
			rd(LCD_OFS_ACC);
			chk(rv, (k == 1) ? 32'h1234_56ff : 32'h1234_5600);
		end
	endtask : sc_set_byte_from_carry
	// Flag bits 18 to 21 set, then cleared; variant keeps 19 and 20 low
	task automatic sc_flags;
		wr(LCD_OFS_FLAGS, 32'h003c_0000);
		rd(LCD_OFS_FLAGS);
		chk(rv, 32'h003c_0002);
		chk(rv2, 32'h0024_0002);
		wr(LCD_OFS_FLAGS, 32'h0);
		rd(LCD_OFS_FLAGS);
		chk(rv, 32'h0000_0002);
	endtask : sc_flags
	// Pushes of the pointer and of flags in real mode
	task automatic sc_push;
		wr(LCD_OFS_SP, 32'h100);
		run(32'h0, 32'h0000_0054, 32'h0, 1'b0);
		rd(LCD_OFS_PUSH);
		chk(rv, 32'h100);
		rd(LCD_OFS_SP);
		chk(rv, 32'hfc);
		wr(LCD_OFS_FLAGS, 32'h0000_f000);
		run(32'h2, 32'h0000_009c, 32'h0, 1'b0);
		rd(LCD_OFS_PUSH);
		chk(rv, 32'h0000_7002);
	endtask : sc_push
	// Main sequence
	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		sc_reset();
		sc_faults();
		sc_alu();
		sc_shift();
		sc_test();
		sc_set_byte_from_carry();
		sc_flags();
		sc_push();
		report_and_stop();
	end
	// Watchdog, well beyond the roughly 600 cycles needed
	initial
	begin
		repeat (20000) @(posedge hclk);
		fail_count++;
		report_and_stop();
	end
endmodule : lcd_core_tb
